/* common/ofr_pkg.sv */
// Package of selector codes, reset defaults and widths for the output function router
package ofr_pkg;

  localparam int OFR_SEL_W = 4;
  localparam int OFR_MV_W = 8;
  localparam int OFR_NUM_OUT = 4;
  localparam int OFR_NUM_WB = 8;

  typedef enum logic [OFR_SEL_W-1:0] {
    OFR_NO_FUNCTION,
    OFR_HEAT,
    OFR_COOL,
    OFR_ALARM_ONE_SOURCE,
    OFR_ALARM_TWO_SOURCE,
    OFR_ALARM_THREE_SOURCE,
    OFR_PROGRAM_END,
    OFR_SWITCH_COUNT_ALARM,
    OFR_WORK_BIT_ONE,
    OFR_WORK_BIT_TWO,
    OFR_WORK_BIT_THREE,
    OFR_WORK_BIT_FOUR,
    OFR_WORK_BIT_FIVE,
    OFR_WORK_BIT_SIX,
    OFR_WORK_BIT_SEVEN,
    OFR_LOGIC_WORK_BIT_EIGHT
  } ofr_func_e;

  // Output slot indices
  localparam int OFR_IDX_CTL1 = 0;
  localparam int OFR_IDX_CTL2 = 1;
  localparam int OFR_IDX_AUX1 = 2;
  localparam int OFR_IDX_AUX2 = 3;

  // Reset defaults of the four selectors
  localparam ofr_func_e OFR_RST_CTL1 = OFR_HEAT;
  localparam ofr_func_e OFR_RST_CTL2 = OFR_NO_FUNCTION;
  localparam ofr_func_e OFR_RST_AUX1 = OFR_ALARM_ONE_SOURCE;
  localparam ofr_func_e OFR_RST_AUX2 = OFR_ALARM_TWO_SOURCE;

  // Manipulated value equal to zero percent
  localparam logic [OFR_MV_W-1:0] OFR_MV_ZERO = 8'h00;

  // True for any of the alarm, program end, count alarm or work bit codes
  function automatic logic ofr_is_discrete(input ofr_func_e f);
    ofr_is_discrete = (f >= OFR_ALARM_ONE_SOURCE);
  endfunction : ofr_is_discrete

  function automatic logic ofr_is_work_bit(input ofr_func_e f);
    ofr_is_work_bit = (f >= OFR_WORK_BIT_ONE);
  endfunction : ofr_is_work_bit

endpackage : ofr_pkg

/* hdl/ofr_sel_filter.sv */
// Acceptance filter for one selector write
`timescale 1ns/1ps
module ofr_sel_filter
  import ofr_pkg::*;
(
  input wire logic [OFR_SEL_W-1:0] code_in, // Requested function code
  input wire logic is_ctl, // Slot is a control output
  input wire logic linear_out, // Slot hardware is a linear output
  input wire logic logic_op_en, // Logic operation function in use
  output logic accept // Code may be stored
);

  ofr_func_e f;
  logic lin_block;
  logic wb_block;

  assign f = ofr_func_e'(code_in);
  // Discrete sources need a relay or SSR type control output
  assign lin_block = is_ctl && linear_out && ofr_is_discrete(f);
  // Work bits are not offered while logic operation is unused
  assign wb_block = !logic_op_en && ofr_is_work_bit(f);
  assign accept = !lin_block && !wb_block;

endmodule : ofr_sel_filter

/* hdl/ofr_out_drive.sv */
// Drives one physical output from its selected source
`timescale 1ns/1ps
module ofr_out_drive
  import ofr_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [OFR_SEL_W-1:0] sel, // Current selector
  input wire logic present, // Output exists and is available
  input wire logic heat_cool, // Heating/cooling mode
  input wire logic prog_on, // Program pattern not off
  input wire logic ignore_pend, // Treat program end as no function
  input wire logic [OFR_MV_W-1:0] heat_mv, // Heating manipulated value
  input wire logic [OFR_MV_W-1:0] cool_mv, // Cooling manipulated value
  input wire logic [2:0] alarm_in, // Alarms one to three
  input wire logic prog_end, // Program end status
  input wire logic count_alarm, // On/off count alarm
  input wire logic [OFR_NUM_WB-1:0] work_bits, // Logic work bits
  output logic [OFR_MV_W-1:0] mv_out, // Proportional drive
  output logic on_out // Discrete drive
);

  ofr_func_e f;
  logic [OFR_MV_W-1:0] mv_nxt;
  logic [OFR_MV_W-1:0] mv_r;
  logic on_nxt;
  logic on_r;
  logic [OFR_MV_W-1:0] cool_val;
  logic pend_val;
  logic [2:0] wb_idx;

  assign f = ofr_func_e'(sel);
  assign cool_val = heat_cool ? cool_mv : OFR_MV_ZERO;
  assign pend_val = prog_end && prog_on && !ignore_pend;
  assign wb_idx = sel[2:0];

  always_comb begin
    mv_nxt = OFR_MV_ZERO;
    on_nxt = 1'b0;
    if (present) begin
      unique case (f)
        OFR_NO_FUNCTION: begin
          mv_nxt = OFR_MV_ZERO;
        end
        OFR_HEAT: begin
          mv_nxt = heat_mv;
          on_nxt = (heat_mv != OFR_MV_ZERO);
        end
        OFR_COOL: begin
          mv_nxt = cool_val;
          on_nxt = (cool_val != OFR_MV_ZERO);
        end
        OFR_ALARM_ONE_SOURCE: on_nxt = alarm_in[0];
        OFR_ALARM_TWO_SOURCE: on_nxt = alarm_in[1];
        OFR_ALARM_THREE_SOURCE: on_nxt = alarm_in[2];
        OFR_PROGRAM_END: on_nxt = pend_val;
        OFR_SWITCH_COUNT_ALARM: on_nxt = count_alarm;
        default: on_nxt = work_bits[wb_idx];
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mv_r <= OFR_MV_ZERO;
      on_r <= 1'b0;
    end else begin
      mv_r <= mv_nxt;
      on_r <= on_nxt;
    end
  end

  assign mv_out = mv_r;
  assign on_out = on_r;

endmodule : ofr_out_drive

/* hdl/ofr_router.sv */
// Output function router: selectors, automatic reassignment and routing to four outputs
//
// What this block does
// - Four outputs each have a selector: none, heat, cool, alarms, end, count, work bits.
// - Control output one selector resets to heating control.
// - Control output two selector resets to no function.
// - Auxiliary output one selector resets to alarm one.
// - Auxiliary output two selector resets to alarm two.
// - Cooling selected under standard control drives zero percent.
// - Discrete sources on control outputs only for relay, SSR voltage or SSR types.
// - Program end selectable with pattern off, but then never asserts.
// - Control output two ignores program end while pattern is off.
// - Work bit choices hidden while logic operation is unused.
// - Heating/cooling mode switches control output two selector to cooling.
// - Changing auxiliary one while pattern is on forces program end.
// - Without control output two, heating/cooling switches auxiliary two to cooling.
// - Control output one selector available only under its three conditions.
// - Control output two selector available only under its four conditions.
// - Auxiliary selectors exist only when the auxiliary output is present.
`timescale 1ns/1ps
module ofr_router
  import ofr_pkg::*;
(
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic heat_cool, // Control mode is heating/cooling
  input wire logic prog_on, // Program pattern setting not off
  input wire logic logic_op_en, // Logic operation function in use
  input wire logic has_xfer, // Transfer output fitted
  input wire logic xfer_type_off, // Transfer output type set off
  input wire logic ctl1_linear, // Control output one is linear
  input wire logic ctl2_linear, // Control output two is linear
  input wire logic has_ctl2, // Control output two fitted
  input wire logic has_aux1, // Auxiliary output one fitted
  input wire logic has_aux2, // Auxiliary output two fitted
  input wire logic [OFR_NUM_OUT-1:0] sel_wr, // Selector write strobes, one per output
  input wire logic [OFR_SEL_W-1:0] sel_wdata, // Selector write code
  input wire logic [OFR_MV_W-1:0] heat_mv, // Heating manipulated value
  input wire logic [OFR_MV_W-1:0] cool_mv, // Cooling manipulated value
  input wire logic alarm_one_source, // Alarm one status
  input wire logic alarm_two_source, // Alarm two status
  input wire logic alarm_three_source, // Alarm three status
  input wire logic prog_end, // Program end status
  input wire logic switch_count_alarm, // On/off count alarm status
  input wire logic [OFR_NUM_WB-1:0] work_bits, // Logic work bits one to eight
  output logic [OFR_SEL_W-1:0] ctl1_sel, // Control output one selector
  output logic [OFR_SEL_W-1:0] ctl2_sel, // Control output two selector
  output logic [OFR_SEL_W-1:0] aux1_sel, // Auxiliary output one selector
  output logic [OFR_SEL_W-1:0] aux_two_select, // Auxiliary output two selector
  output logic [OFR_NUM_OUT-1:0] sel_avail, // Selector available per output
  output logic [OFR_NUM_OUT-1:0] out_on, // Discrete drive per output
  output logic [OFR_MV_W-1:0] ctl1_mv, // Control output one proportional drive
  output logic [OFR_MV_W-1:0] ctl2_mv // Control output two proportional drive
);

  // ****************************************
  // Availability
  // ****************************************
  logic avail_ctl1;
  logic avail_ctl2;
  logic [OFR_NUM_OUT-1:0] is_ctl;
  logic [OFR_NUM_OUT-1:0] lin;
  logic [OFR_NUM_OUT-1:0] accept;
  logic [OFR_NUM_OUT-1:0] wr_ok;

  assign avail_ctl1 = has_xfer || !ctl1_linear || xfer_type_off;
  assign avail_ctl2 = has_ctl2 && (has_xfer || ctl1_linear || !ctl2_linear || xfer_type_off);
  assign sel_avail = {has_aux2, has_aux1, avail_ctl2, avail_ctl1};
  assign is_ctl = 4'h3;
  assign lin = {1'b0, 1'b0, ctl2_linear, ctl1_linear};

  // ****************************************
  // Selector storage
  // ****************************************
  logic [OFR_SEL_W-1:0] sel_r [OFR_NUM_OUT];
  logic [OFR_SEL_W-1:0] sel_nxt [OFR_NUM_OUT];
  logic heat_cool_r;
  logic hc_rise;

  assign hc_rise = heat_cool && !heat_cool_r;

  genvar gi;
  generate
    for (gi = 0; gi < OFR_NUM_OUT; gi++) begin : g_sel
      ofr_sel_filter u_filt (
        .code_in(sel_wdata),
        .is_ctl(is_ctl[gi]),
        .linear_out(lin[gi]),
        .logic_op_en(logic_op_en),
        .accept(accept[gi])
      );
      assign wr_ok[gi] = sel_wr[gi] && sel_avail[gi] && accept[gi];
    end
  endgenerate

  // Next selector values with automatic reassignment
  always_comb begin
    for (int i = 0; i < OFR_NUM_OUT; i++) begin
      sel_nxt[i] = wr_ok[i] ? sel_wdata : sel_r[i];
    end
    if (wr_ok[OFR_IDX_AUX1] && prog_on) begin
      sel_nxt[OFR_IDX_AUX1] = OFR_PROGRAM_END;
    end
    if (hc_rise && has_ctl2) begin
      sel_nxt[OFR_IDX_CTL2] = OFR_COOL;
    end
    if (hc_rise && !has_ctl2) begin
      sel_nxt[OFR_IDX_AUX2] = OFR_COOL;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      heat_cool_r <= 1'b0;
    end else begin
      heat_cool_r <= heat_cool;
    end
  end

  generate
    for (gi = 0; gi < OFR_NUM_OUT; gi++) begin : g_reg
      // Reset code per slot is a constant, so the reset branch loads no logic
      localparam logic [OFR_SEL_W-1:0] RST_CODE = (gi == OFR_IDX_CTL1) ? OFR_RST_CTL1 :
        (gi == OFR_IDX_CTL2) ? OFR_RST_CTL2 :
        (gi == OFR_IDX_AUX1) ? OFR_RST_AUX1 : OFR_RST_AUX2;
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          sel_r[gi] <= RST_CODE;
        end else begin
          sel_r[gi] <= sel_nxt[gi];
        end
      end
    end
  endgenerate

  assign ctl1_sel = sel_r[OFR_IDX_CTL1];
  assign ctl2_sel = sel_r[OFR_IDX_CTL2];
  assign aux1_sel = sel_r[OFR_IDX_AUX1];
  assign aux_two_select = sel_r[OFR_IDX_AUX2];

  // ****************************************
  // Output drive
  // ****************************************
  logic [OFR_MV_W-1:0] mv_all [OFR_NUM_OUT];
  logic [OFR_NUM_OUT-1:0] ign_pend;
  logic [2:0] alarms;

  assign alarms = {alarm_three_source, alarm_two_source, alarm_one_source};
  assign ign_pend = {1'b0, 1'b0, !prog_on, 1'b0};

  generate
    for (gi = 0; gi < OFR_NUM_OUT; gi++) begin : g_drv
      ofr_out_drive u_drv (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .sel(sel_r[gi]),
        .present(sel_avail[gi]),
        .heat_cool(heat_cool),
        .prog_on(prog_on),
        .ignore_pend(ign_pend[gi]),
        .heat_mv(heat_mv),
        .cool_mv(cool_mv),
        .alarm_in(alarms),
        .prog_end(prog_end),
        .count_alarm(switch_count_alarm),
        .work_bits(work_bits),
        .mv_out(mv_all[gi]),
        .on_out(out_on[gi])
      );
    end
  endgenerate

  assign ctl1_mv = mv_all[OFR_IDX_CTL1];
  assign ctl2_mv = mv_all[OFR_IDX_CTL2];

endmodule : ofr_router

/* bench/ofr_drv_model.sv */
// Behavioural relay, SSR and linear stages on the far side of the router
`timescale 1ns/1ps
module ofr_drv_model
  import ofr_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic [OFR_NUM_OUT-1:0] out_on, // Discrete drives
  input wire logic [OFR_MV_W-1:0] ctl1_mv, // Control one level
  input wire logic [OFR_MV_W-1:0] ctl2_mv, // Control two level
  output logic [OFR_NUM_OUT-1:0] relay_q // Stage states
);
  // Stages settle one cycle late; a linear stage counts as on at any nonzero level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      relay_q <= '0;
    end else begin
      relay_q <= out_on | {2'h0, ctl2_mv != 8'h00, ctl1_mv != 8'h00};
    end
  end
endmodule : ofr_drv_model

/* bench/ofr_router_checker.sv */
// Concurrent checks on the output function router ports
`timescale 1ns/1ps
module ofr_router_checker
  import ofr_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic arst_n, // Reset
  input wire logic heat_cool, // Mode
  input wire logic prog_on, // Pattern on
  input wire logic logic_op_en, // Logic in use
  input wire logic ctl1_linear, // Linear one
  input wire logic has_ctl2, // Ctl2 fitted
  input wire logic has_aux1, // Aux1 fitted
  input wire logic has_aux2, // Aux2 fitted
  input wire logic [OFR_NUM_OUT-1:0] sel_wr, // Strobes
  input wire logic [OFR_SEL_W-1:0] sel_wdata, // Code
  input wire logic [OFR_MV_W-1:0] heat_mv, // Heat level
  input wire logic alarm_one_source, // Alarm one
  input wire logic [OFR_SEL_W-1:0] ctl1_sel, // Sel one
  input wire logic [OFR_SEL_W-1:0] ctl2_sel, // Sel two
  input wire logic [OFR_SEL_W-1:0] aux1_sel, // Aux one sel
  input wire logic [OFR_SEL_W-1:0] aux_two_select, // Aux two sel
  input wire logic [OFR_NUM_OUT-1:0] sel_avail, // Availability
  input wire logic [OFR_NUM_OUT-1:0] out_on, // Drives
  input wire logic [OFR_MV_W-1:0] ctl1_mv // Level one
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_aux1_wr; sel_wr[2] && sel_avail[2] && prog_on && (logic_op_en || sel_wdata < 4'h8); endsequence
  sequence s_hc_rise; $rose(heat_cool); endsequence
  property p_off; ctl2_sel == OFR_NO_FUNCTION |=> !out_on[1]; endproperty
  property p_alarm; aux1_sel == OFR_ALARM_ONE_SOURCE && sel_avail[2] |=> out_on[2] == $past(alarm_one_source); endproperty
  property p_cool_std; ctl1_sel == OFR_COOL && !heat_cool |=> ctl1_mv == OFR_MV_ZERO; endproperty
  property p_heat; ctl1_sel == OFR_HEAT && sel_avail[0] |=> ctl1_mv == $past(heat_mv); endproperty
  property p_pend_off; aux1_sel == OFR_PROGRAM_END && !prog_on |=> !out_on[2]; endproperty
  property p_aux1_force; s_aux1_wr |=> aux1_sel == OFR_PROGRAM_END; endproperty
  property p_hc_ctl2; s_hc_rise ##0 has_ctl2 |=> ctl2_sel == OFR_COOL; endproperty
  property p_hc_aux2; s_hc_rise ##0 (!has_ctl2 && has_aux2) |=> aux_two_select == OFR_COOL; endproperty
  property p_wb_hidden; sel_wr[3] && !logic_op_en && sel_wdata >= 4'h8 && !heat_cool |=> $stable(aux_two_select); endproperty
  property p_lin_refuse; sel_wr[0] && ctl1_linear && sel_wdata >= 4'h3 |=> $stable(ctl1_sel); endproperty
  property p_aux_present; sel_avail[3:2] == {has_aux2, has_aux1}; endproperty
  property p_aux1_absent; !has_aux1 |=> !out_on[2]; endproperty
  a_off: assert property (p_off) else $error("output with no function driven");
  a_alarm: assert property (p_alarm) else $error("alarm one not routed");
  a_cool_std: assert property (p_cool_std) else $error("cooling under standard not zero");
  a_heat: assert property (p_heat) else $error("heating level not routed");
  a_pend_off: assert property (p_pend_off) else $error("program end asserted with pattern off");
  a_aux1_force: assert property (p_aux1_force) else $error("aux one not forced to program end");
  a_hc_ctl2: assert property (p_hc_ctl2) else $error("ctl two not switched to cooling");
  a_hc_aux2: assert property (p_hc_aux2) else $error("aux two not switched to cooling");
  a_wb_hidden: assert property (p_wb_hidden) else $error("work bit accepted while logic unused");
  a_lin_refuse: assert property (p_lin_refuse) else $error("discrete code on linear output");
  a_aux_present: assert property (p_aux_present) else $error("aux availability wrong");
  a_aux1_absent: assert property (p_aux1_absent) else $error("absent aux one driven");
endmodule : ofr_router_checker
bind ofr_router ofr_router_checker ofr_router_checker_inst (.*);

/* bench/test_ofr_router.sv */
// Self-checking bench for the output function router
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; $display("BAD %0t mismatch", $time); end end
module test_ofr_router
  import ofr_pkg::*;
();
  typedef struct {int kind; logic [7:0] v;} ofr_note_s;
  ofr_note_s notes[$];
  ofr_note_s n;
  int failures = 0, checked = 0, r;
  int seed = 32'h02bc532d;
  event chk_ev;
  logic clk_sys = 0, arst_n = 0, heat_cool = 0, prog_on = 0, logic_op_en = 1, has_xfer = 1, xfer_type_off = 0;
  logic ctl1_linear = 0, ctl2_linear = 0, has_ctl2 = 1, has_aux1 = 1, has_aux2 = 1, prog_end = 0;
  logic alarm_one_source = 0, alarm_two_source = 0, alarm_three_source = 0, switch_count_alarm = 0;
  logic [3:0] sel_wr = 4'h0, sel_wdata = 4'h0, ctl1_sel, ctl2_sel, aux1_sel, aux_two_select, sel_avail, out_on, relay_q;
  logic [7:0] heat_mv = 8'h00, cool_mv = 8'h00, work_bits = 8'h00, ctl1_mv, ctl2_mv, obs;
  logic [3:0] e_sel [4] = '{4'h1, 4'h0, 4'h3, 4'h4};
  ofr_router ofr_router_inst (.*);
  ofr_drv_model ofr_drv_model_inst (.*);
  always #20 clk_sys = ~clk_sys;
  function automatic logic exp_on(input logic [3:0] c);
    case (c)
      4'h0: exp_on = 1'b0;
      4'h1: exp_on = heat_mv != 8'h00;
      4'h2: exp_on = heat_cool && cool_mv != 8'h00;
      4'h3: exp_on = alarm_one_source;
      4'h4: exp_on = alarm_two_source;
      4'h5: exp_on = alarm_three_source;
      4'h6: exp_on = prog_on && prog_end;
      4'h7: exp_on = switch_count_alarm;
      default: exp_on = work_bits[c[2:0]];
    endcase
  endfunction : exp_on
  function automatic logic [3:0] av();
    av = {has_aux2, has_aux1, has_ctl2 && (has_xfer || ctl1_linear || !ctl2_linear || xfer_type_off),
          has_xfer || !ctl1_linear || xfer_type_off};
  endfunction : av
  task automatic note(input int k, input logic [7:0] v);
    notes.push_back('{k, v});
  endtask : note
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : tick
  task automatic chk_all();
    logic [3:0] e;
    for (int i = 0; i < 4; i++) note(i, {4'h0, e_sel[i]});
    e = av() & {exp_on(e_sel[3]), exp_on(e_sel[2]), exp_on(e_sel[1]), exp_on(e_sel[0])};
    note(4, {4'h0, e});
    note(7, {4'h0, e});
    -> chk_ev;
    @(posedge clk_sys);
  endtask : chk_all
  task automatic wr(input logic [3:0] m, input logic [3:0] c);
    @(posedge clk_sys);
    r = $random(seed);
    {alarm_one_source, alarm_two_source, alarm_three_source, prog_end, switch_count_alarm} <= r[4:0];
    heat_mv <= r[12:5];
    cool_mv <= r[20:13];
    work_bits <= r[28:21];
    sel_wr <= m;
    sel_wdata <= c;
    @(posedge clk_sys);
    sel_wr <= 4'h0;
    tick(2);
  endtask : wr
  task automatic tally_and_finish();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Monitor: compares every queued note, oldest first, with outputs
  // ****************************************
  initial forever begin
    @(chk_ev);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        0: obs = {4'h0, ctl1_sel};
        1: obs = {4'h0, ctl2_sel};
        2: obs = {4'h0, aux1_sel};
        3: obs = {4'h0, aux_two_select};
        4: obs = {4'h0, out_on};
        5: obs = {4'h0, sel_avail};
        6: obs = ctl1_mv;
        7: obs = {4'h0, relay_q};
        default: obs = ctl2_mv;
      endcase
      `CHK(obs, n.v)
    end
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(1);
    chk_all();
    for (int c = 0; c < 16; c++) begin
      prog_on <= c[0];
      e_sel[3] = c[3:0];
      wr(4'h8, c[3:0]);
      chk_all();
    end
    for (int c = 2; c > 0; c--) begin
      e_sel[0] = c[3:0];
      wr(4'h1, c[3:0]);
      note(6, c == 2 ? 8'h00 : heat_mv);
      chk_all();
    end
    prog_on <= 1'b0;
    e_sel[1] = 4'h6;
    wr(4'h2, 4'h6);
    chk_all();
    prog_on <= 1'b1;
    e_sel[2] = 4'h6;
    wr(4'h4, 4'h3);
    chk_all();
    prog_on <= 1'b0;
    logic_op_en <= 1'b0;
    wr(4'h8, 4'h9);
    chk_all();
    logic_op_en <= 1'b1;
    ctl1_linear <= 1'b1;
    wr(4'h1, 4'h3);
    chk_all();
    ctl1_linear <= 1'b0;
    heat_cool <= 1'b1;
    e_sel[1] = 4'h2;
    tick(3);
    note(8, cool_mv);
    chk_all();
    heat_cool <= 1'b0;
    has_ctl2 <= 1'b0;
    repeat (2) @(posedge clk_sys);
    heat_cool <= 1'b1;
    e_sel[3] = 4'h2;
    tick(3);
    note(8, 8'h00);
    chk_all();
    for (int i = 0; i < 16; i++) begin
      {has_xfer, ctl1_linear, ctl2_linear, xfer_type_off} <= i[3:0];
      {has_ctl2, has_aux1} <= {1'b1, i[1]};
      tick(1);
      note(5, {4'h0, av()});
      -> chk_ev;
      @(posedge clk_sys);
    end
    tally_and_finish();
  end
endmodule : test_ofr_router
